// [bench/cdf_flag_bank_properties.sv]
/* Port checker for the flag bank.
   Assumes single word transfers and causes on hclk. */
module cdf_flag_bank_properties
  import cdf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cdf_cause_t cause,
  input wire cdf_state_t can_state,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire tk = hsel && hready && htrans[1];
  wire wr_ctrl = tk && hwrite && haddr[7:0] == CDF_OFS_CTRL;
  logic rd_d, rdf_d, en_d;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      {rd_d, rdf_d, en_d} <= 3'h0;
    else
      {rd_d, rdf_d, en_d} <= {tk && !hwrite, tk && !hwrite && haddr[7:0] == CDF_OFS_FLAGS,
        tk && hwrite && haddr[7:0] == CDF_OFS_IRQ_EN};
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_idle_rdata: assert property (!rd_d |-> hrdata == 32'h0) else $error("hrdata not zero");
  a_flag_sets: assert property (rdf_d |-> (hrdata[9:0] & $past(cause, 2)) == $past(cause, 2))
    else $error("flag missing");
  a_txd_drv_off: assert property ($rose(cause.txd_dom) |-> ##[1:3] !can_state.drv_en)
    else $error("driver stays on");
  a_rcv_by_host: assert property ($fell(can_state.rcv_en) |-> $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("receiver off unasked");
  a_irq_masked: assert property (en_d && hwdata == 32'h0 |-> ##[1:2] !irq) else $error("irq unmasked");
  a_wake_boot: assert property ($rose(hresetn) |-> ##[1:2] can_state.wake_rcv_en)
    else $error("wake receiver off");
  cover property (rdf_d && hrdata[9:0] != 10'h0);
  cover property ($rose(irq));
  cover property ($fell(can_state.drv_en));
endmodule : cdf_flag_bank_properties
bind cdf_flag_bank cdf_flag_bank_properties cdf_flag_bank_properties_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cause(cause), .can_state(can_state), .irq(irq));

// [bench/cdf_host.sv]
/* Host model: an AHB-Lite master doing single word transfers.
   Assumes one slave whose hreadyout is the bus hready. */
module cdf_host
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  // Reads are issued freely, as polling has no side effect on state bits.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : cdf_host

// [bench/testbench.sv]
/* Self-checking bench for the flag bank.
   The host model drives the bus; causes are driven here. */
module testbench;
  import cdf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  cdf_cause_t cause = '0;
  cdf_state_t can_state;
  int n_mismatch = 0;
  int compares = 0;
  always #10 hclk = ~hclk;
  cdf_host cdf_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  cdf_flag_bank cdf_flag_bank_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cause(cause), .can_state(can_state), .irq(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] wd, input string n, input logic [31:0] e);
    cdf_host_i.xfer(w, a, wd, d);
    if (!w)
      chk(n, e, d);
  endtask : rw
  task automatic t_state;
    rw(1'b0, CDF_OFS_STATE, 32'h0, "state boot", 32'h7);
    rw(1'b0, 8'h40, 32'h0, "unmapped", 32'h0);
    rw(1'b1, CDF_OFS_CTRL, 32'h0, "", 32'h0);
    rw(1'b0, CDF_OFS_STATE, 32'h0, "state off", 32'h0);
    rw(1'b1, CDF_OFS_CTRL, 32'h7, "", 32'h0);
    rw(1'b0, CDF_OFS_FLAGS, 32'h0, "flags", 32'h0);
    rw(1'b0, CDF_OFS_STATE, 32'h0, "state polled", 32'h7);
    chk("can_state pins", 32'h7, {29'h0, can_state});
    $display("t_state done");
  endtask : t_state
  task automatic t_flags;
    cdf_cause_t c;
    for (int i = 0; i < CDF_NFLAG; i++)
    begin
      c = cdf_cause_t'(10'h1 << i);
      cause <= c;
      repeat (2) @(posedge hclk);
      for (int k = 0; k < 4; k++)
      begin
        if (k == 2)
          cause <= '0;
        rw(1'b0, CDF_OFS_FLAGS, 32'h0, "flags", k < 3 ? 32'(c) : 32'h0);
      end
      if (c.txd_dom)
      begin
        rw(1'b0, CDF_OFS_STATE, 32'h0, "drv latched", 32'h6);
        rw(1'b1, CDF_OFS_CTRL, 32'hf, "", 32'h0);
        rw(1'b0, CDF_OFS_STATE, 32'h0, "drv rearmed", 32'h7);
      end
    end
    $display("t_flags done");
  endtask : t_flags
  task automatic t_irq;
    rw(1'b0, CDF_OFS_IRQ_STAT, 32'h0, "irq stat", 32'h3ff);
    rw(1'b0, CDF_OFS_IRQ_EN, 32'h0, "irq en", 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rw(1'b1, CDF_OFS_IRQ_EN, 32'h3ff, "", 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq on", 32'h1, {31'h0, irq});
    rw(1'b1, CDF_OFS_IRQ_CLR, 32'h3ff, "", 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rw(1'b1, CDF_OFS_IRQ_EN, 32'h0, "", 32'h0);
    rw(1'b0, CDF_OFS_IRQ_STAT, 32'h0, "irq stat clr", 32'h0);
    $display("t_irq done");
  endtask : t_irq
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_state;
    t_flags;
    t_irq;
    summarize;
  end
  initial
  begin
    #100000;
    n_mismatch++;
    summarize;
  end
endmodule : testbench

// [pkg/cdf_pkg.sv]
/*
  Package for the CAN diagnostic flag bank: register offsets, field positions,
  reset values and the carrier structs shared with the bench.
  Assumes a single AHB-Lite master and 32-bit word transfers.
*/
package cdf_pkg;

  localparam logic [7:0] CDF_OFS_STATE = 8'h00;
  localparam logic [7:0] CDF_OFS_FLAGS = 8'h04;
  localparam logic [7:0] CDF_OFS_CTRL = 8'h08;
  localparam logic [7:0] CDF_OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] CDF_OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] CDF_OFS_IRQ_CLR = 8'h14;
  localparam int CDF_ADDR_W = 8;

  localparam int CDF_NFLAG = 10;

  // Flag positions follow the packing of cdf_cause_t, whose last member is bit 0.
  localparam int CDF_F_OTEMP = 0;
  localparam int CDF_F_RXD_LOW = 1;
  localparam int CDF_F_RXD_HIGH = 2;
  localparam int CDF_F_TXD_DOM = 3;
  localparam int CDF_F_BUS_CLAMP = 4;
  localparam int CDF_F_OCUR = 5;
  localparam int CDF_F_UNCONF = 6;
  localparam int CDF_F_CONF = 7;
  localparam int CDF_F_CANL_BAT = 8;
  localparam int CDF_F_WAKE = 9;

  localparam int CDF_S_DRV = 0;
  localparam int CDF_S_RCV = 1;
  localparam int CDF_S_WAKE_RCV = 2;

  localparam int CDF_C_DRV_EN = 0;
  localparam int CDF_C_RCV_EN = 1;
  localparam int CDF_C_WAKE_RCV_EN = 2;
  localparam int CDF_C_DRV_REARM = 3;

  localparam logic [3:0] CDF_CTRL_RESET = 4'h7;

  typedef struct packed {
    logic wake;
    logic canl_bat;
    logic conf;
    logic unconf;
    logic ocur;
    logic bus_clamp;
    logic txd_dom;
    logic rxd_high;
    logic rxd_low;
    logic otemp;
  } cdf_cause_t;

  typedef struct packed {
    logic wake_rcv_en;
    logic rcv_en;
    logic drv_en;
  } cdf_state_t;

endpackage : cdf_pkg

// [verilog/cdf_flag_bank.sv]
/*
  CAN diagnostic flag bank with AHB-Lite slave, real-time state bits, latched
  fault flags and an interrupt.
  Assumes the cause inputs come from synchronous detector logic on hclk, one
  AHB-Lite master, word transfers only.
*/
// The address map and register access over AHB-Lite were left to the implementer.
// Operation
// RULE_01 - Driver-state bit follows transmitter enable live: 1 enabled, 0 disabled.
// RULE_02 - Transmitter disabled by host control bit or automatically on TXD-dominant fault.
// RULE_03 - Reading flags never alters the driver, receiver or wake-receiver state bits.
// RULE_04 - Receiver-state bit shows 1 while receiver enabled, 0 while disabled.
// RULE_05 - Receiver is disabled only by the host control bit.
// RULE_06 - Wake-receiver state bit shows its host-controlled enable.
// RULE_07 - Wake receiver is enabled after reset until the host disables it.
// RULE_08 - Wake flag sets on bus wake-up and clears on host read.
// RULE_09 - Over-temperature flag clears only once below threshold and read.
// RULE_10 - RXD-low flag sets on short to ground; clears after recovery and read.
// RULE_11 - RXD-high flag sets on recessive stuck; clears after recovery and read.
// RULE_12 - TXD-dominant flag sets on TXD held low; clears after recovery and read.
// RULE_13 - Bus-clamp flag sets on dominant timeout; clears after recovery and read.
// RULE_14 - Over-current flag clears only once current below threshold and read.
// RULE_15 - Unconfirmed bus-failure flag sets at pre-detection; clears after recovery, read.
// RULE_16 - Confirmed bus-failure flag sets on full detection; clears after recovery, read.
// RULE_17 - CANL-to-battery flag sets on short; clears after recovery and read.
// RULE_18 - A read while the fault persists leaves the flag set; a later read clears.
module cdf_flag_bank
  import cdf_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire cdf_cause_t cause,
  output cdf_state_t can_state,
  output logic irq
);

  // Address phase capture.
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [CDF_ADDR_W-1:0] addr_reg;
  logic [31:0] hrdata_reg;

  wire addr_valid = hsel && hready && htrans[1];
  wire addr_ok = (haddr[1:0] == 2'h0) && (hsize == 3'h2);
  wire [CDF_ADDR_W-1:0] a_now = haddr[CDF_ADDR_W-1:0];

  // Control and flag state.
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic drv_fault_reg;
  logic [CDF_NFLAG-1:0] flag_reg;
  logic [CDF_NFLAG-1:0] flag_next;
  logic [CDF_NFLAG-1:0] irq_stat_reg;
  logic [CDF_NFLAG-1:0] irq_en_reg;
  cdf_state_t state_reg;

  function automatic logic hit(input logic [CDF_ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire [CDF_NFLAG-1:0] cause_vec = cause;
  wire wr_now = wr_pend_reg;
  // Flag read is the address phase of a read of the flag word.
  wire flag_read = addr_valid && !hwrite && addr_ok && hit(a_now, CDF_OFS_FLAGS);
  wire wr_ctrl = wr_now && hit(addr_reg, CDF_OFS_CTRL);
  wire wr_en = wr_now && hit(addr_reg, CDF_OFS_IRQ_EN);
  wire wr_clr = wr_now && hit(addr_reg, CDF_OFS_IRQ_CLR);
  wire [CDF_NFLAG-1:0] clr_vec = wr_clr ? hwdata[CDF_NFLAG-1:0] : '0;

  // Wake flag has no persistent cause; all others need recovery before a read clears them.
  wire [CDF_NFLAG-1:0] persist_mask = ~(CDF_NFLAG'(1) << CDF_F_WAKE);

  genvar gi;
  generate
    for (gi = 0; gi < CDF_NFLAG; gi++)
    begin : g_flag
      // The set term is tested first so an event in the read cycle is never lost.
      assign flag_next[gi] = cause_vec[gi] ? 1'b1 :
        (flag_read && !(persist_mask[gi] && cause_vec[gi])) ? 1'b0 : flag_reg[gi]; // RULE_08 RULE_09 RULE_10 RULE_11 RULE_12 RULE_13 RULE_14 RULE_15 RULE_16 RULE_17 RULE_18
    end
  endgenerate

  assign ctrl_next = wr_ctrl ? hwdata[3:0] : ctrl_reg;

  // Automatic driver shutdown holds until the host rearms it after TXD recovers.
  wire drv_fault_next = cause.txd_dom ? 1'b1 :
    (wr_ctrl && hwdata[CDF_C_DRV_REARM]) ? 1'b0 : drv_fault_reg; // RULE_02

  cdf_state_t state_next;
  assign state_next.drv_en = ctrl_reg[CDF_C_DRV_EN] && !drv_fault_reg; // RULE_01 RULE_02
  assign state_next.rcv_en = ctrl_reg[CDF_C_RCV_EN]; // RULE_04 RULE_05
  assign state_next.wake_rcv_en = ctrl_reg[CDF_C_WAKE_RCV_EN]; // RULE_06 RULE_07

  wire [CDF_NFLAG-1:0] irq_stat_next = cause_vec | (irq_stat_reg & ~clr_vec);

  wire [31:0] rd_mux =
    hit(addr_reg, CDF_OFS_STATE) ? {29'h0, state_reg} : // RULE_03
    hit(addr_reg, CDF_OFS_FLAGS) ? {22'h0, flag_reg} :
    hit(addr_reg, CDF_OFS_CTRL) ? {28'h0, ctrl_reg[3] & 1'b0, ctrl_reg[2:0]} :
    hit(addr_reg, CDF_OFS_IRQ_STAT) ? {22'h0, irq_stat_reg} :
    hit(addr_reg, CDF_OFS_IRQ_EN) ? {22'h0, irq_en_reg} : 32'h0;

  // Read data is formed from the address phase so the answer has no wait state.
  function automatic logic [31:0] rd_mux_addr(input logic [CDF_ADDR_W-1:0] a);
    rd_mux_addr =
      hit(a, CDF_OFS_STATE) ? {29'h0, state_reg} :
      hit(a, CDF_OFS_FLAGS) ? {22'h0, flag_reg} :
      hit(a, CDF_OFS_CTRL) ? {29'h0, ctrl_reg[2:0]} :
      hit(a, CDF_OFS_IRQ_STAT) ? {22'h0, irq_stat_reg} :
      hit(a, CDF_OFS_IRQ_EN) ? {22'h0, irq_en_reg} : 32'h0;
  endfunction : rd_mux_addr

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= '0;
      hrdata_reg <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= addr_valid && hwrite && addr_ok;
      rd_pend_reg <= addr_valid && !hwrite;
      addr_reg <= addr_valid ? a_now : addr_reg;
      hrdata_reg <= (addr_valid && !hwrite && addr_ok) ? rd_mux_addr(a_now) : 32'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= CDF_CTRL_RESET; // RULE_07
      drv_fault_reg <= 1'b0;
      flag_reg <= '0;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      state_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      ctrl_reg <= {1'b0, ctrl_next[2:0]};
      drv_fault_reg <= drv_fault_next;
      flag_reg <= flag_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= wr_en ? hwdata[CDF_NFLAG-1:0] : irq_en_reg;
      state_reg <= state_next;
      irq <= |(irq_stat_next & irq_en_reg);
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign can_state = state_reg;

  wire unused_ok = rd_pend_reg ^ (|rd_mux);

endmodule : cdf_flag_bank
